// ===== rtl/lcev_event_fifo.sv
// Transmit event FIFO storage with registered head data
`timescale 1ns/1ps
module lcev_event_fifo
  import lcev_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  push,
  input  wire logic [EVT_DATA_W-1:0] pushData,
  input  wire logic                  pop,
  output logic                       full,
  output logic                       headOk_q,
  output logic [EVT_DATA_W-1:0]      headData_q
);

  logic [EVT_DATA_W-1:0] mem [EVT_DEPTH];
  logic [EVT_PTR_W-1:0]  wrPtr_q;
  logic [EVT_PTR_W-1:0]  rdPtr_q;
  logic [EVT_PTR_W:0]    count_q;

  wire doPush = push && !full;
  wire doPop  = pop && (count_q != '0);

  assign full = (count_q == (EVT_PTR_W+1)'(EVT_DEPTH));

  always_ff @(posedge clk_sys) begin
    if (doPush) begin
      mem[wrPtr_q] <= pushData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      count_q    <= '0;
      headOk_q   <= 1'b0;
      headData_q <= '0;
    end else begin
      wrPtr_q    <= wrPtr_q + EVT_PTR_W'(doPush);
      rdPtr_q    <= rdPtr_q + EVT_PTR_W'(doPop);
      count_q    <= count_q + (EVT_PTR_W+1)'(doPush) - (EVT_PTR_W+1)'(doPop);
      // Head is only trusted one edge after a read pointer move
      headOk_q   <= (count_q != '0) && !doPop;
      headData_q <= mem[rdPtr_q];
    end
  end

endmodule : lcev_event_fifo

// ===== rtl/lcev_pkg.sv
// Constants and carrier types for the line configuration and event registers
package lcev_pkg;

  localparam int NUM_LINES    = 16;
  localparam int NUM_GROUPS   = 4;
  localparam int EVT_DEPTH    = 64;
  localparam int EVT_PTR_W    = 6;
  localparam int EVT_DATA_W   = 15;

  // Control word field positions
  localparam int CW_XADDR_LO  = 4;
  localparam int CW_XADDR_HI  = 5;
  localparam int CW_SEL_LO    = 9;
  localparam int CW_SEL_HI    = 10;
  localparam int CW_DATA_LO   = 11;
  localparam int CW_DATA_HI   = 14;
  localparam int CW_SYNC_RXEN = 13;
  localparam int CW_STROBE    = 15;

  // Select word fields
  localparam int SS_LINE_LO   = 0;
  localparam int SS_LINE_HI   = 3;
  localparam int SS_GRP_LO    = 2;
  localparam int SS_GRP_HI    = 3;

  // Async settings register selection codes
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_FORMAT  = 2'h1;
  localparam logic [1:0] SEL_BAUD    = 2'h2;
  localparam logic [1:0] SEL_MAINT   = 2'h3;

  // Settings nibble bit positions (control bits 11..14 map to 0..3)
  localparam int PR_HALFDUP   = 0;
  localparam int PR_EVENPAR   = 1;
  localparam int PR_RXEN      = 2;
  localparam int PR_BREAK     = 3;
  localparam int FM_LEN_LO    = 0;
  localparam int FM_LEN_HI    = 1;
  localparam int FM_TWOSTOP   = 2;
  localparam int FM_PAREN     = 3;
  localparam int MT_LOOP      = 0;

  // Transmit event word valid flag position
  localparam int EV_VALID     = 15;

  // Reset values
  localparam logic [3:0]  RST_NIBBLE = 4'h0;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [1:0]  RST_SEL    = 2'h0;
  localparam logic [4:0]  RST_GROUP  = 5'h00;
  // Shortest character length; reset value and base of the length code
  localparam logic [3:0]  CHAR_LEN_MIN = 4'h5;

  typedef struct packed {
    logic [3:0] maint;
    logic [3:0] baud;
    logic [3:0] format;
    logic [3:0] primary;
  } lcev_async_set_t;

  typedef struct packed {
    logic [3:0] reason;
    logic [3:0] line;
    logic [7:0] char;
  } lcev_rx_word_t;

  typedef struct packed {
    logic [3:0]  line;
    logic [10:0] cond;
  } lcev_tx_event_t;

endpackage : lcev_pkg

// ===== rtl/lcev_regs.sv
// Line control word, per-line settings, receive interrupt word and transmit event word
`timescale 1ns/1ps
// Functional notes
// - Sync strobe loads receive enable per line
// - Sync strobe loads bits 9-12,14 per group
// - Strobe self-clears; same-write data is stored
// - Bits 10:9 pick one of four settings
// - Async strobe loads bits 11-14 into selection
// - Initialize clears selection code and settings
// - Primary bit 11 half duplex blinds receiver
// - Primary bit 12 chooses even parity
// - Receive enable gates receiver, sets active
// - Primary bit 14 forces break on line
// - Format bits 12:11 give character length
// - Format bit 13 selects two stop bits
// - Format bit 14 enables parity
// - Receive word read-only, character low byte
// - Short sync parity sits above character
// - Receive word holds line and reason
// - Event entry holds condition and line
// - Control bits 5:4 show extended address
// - New head sets valid; read clears it
// - Baud selection stores speed code
// - Maintenance bit 11 loops transmit to receive
module lcev_regs
  import lcev_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   busInit,
  input  wire logic                   ctlWrEn,
  input  wire logic [15:0]            ctlWrData,
  input  wire logic [15:0]            secondary_select_word,
  input  wire logic [1:0]             extAddrHi,
  input  wire logic [NUM_LINES-1:0]   lineAsync,
  input  wire logic                   rxWordLoad,
  input  wire lcev_rx_word_t          rxWordIn,
  input  wire logic                   evtRdEn,
  input  wire logic                   txEvtPush,
  input  wire lcev_tx_event_t         txEvtIn,
  input  wire logic [NUM_LINES-1:0]   txBusy,
  input  wire logic [NUM_LINES-1:0]   txSerial,
  input  wire logic [NUM_LINES-1:0]   rxLineIn,
  input  wire logic [NUM_LINES-1:0]   remoteBusyIn,
  input  wire logic [NUM_LINES-1:0]   rxResync,
  output logic [15:0]                 line_control_word_q,
  output lcev_rx_word_t               receive_interrupt_word_q,
  output logic [15:0]                 transmit_event_word_q,
  output logic                        txEvtFull_q,
  output lcev_async_set_t [NUM_LINES-1:0] asyncSet_q,
  output logic [NUM_LINES-1:0]        syncRxEn_q,
  output logic [NUM_GROUPS-1:0][4:0]  syncGroupCtl_q,
  output logic [NUM_LINES-1:0]        rxGate_q,
  output logic [NUM_LINES-1:0]        rxActive_q,
  output logic [NUM_LINES-1:0]        rxSerial_q,
  output logic [NUM_LINES-1:0]        lineTxd_q,
  output logic [NUM_LINES-1:0]        remoteBusy_q,
  output logic [NUM_LINES-1:0][3:0]   charBits_q,
  output logic [NUM_LINES-1:0]        stopBits2_q,
  output logic [NUM_LINES-1:0]        parityOn_q,
  output logic [NUM_LINES-1:0]        parityEven_q,
  output logic [NUM_LINES-1:0][3:0]   speedCode_q
);

  logic [1:0]            regSel_q;
  logic                  evtValid_q;
  logic [EVT_DATA_W-1:0] evtData_q;
  logic                  fifoFull;
  logic                  headOk;
  logic [EVT_DATA_W-1:0] headData;

  // Strobe decode; the strobe itself is never stored so it always reads zero
  wire       strobe   = ctlWrEn && ctlWrData[CW_STROBE];
  wire [3:0] selLine  = secondary_select_word[SS_LINE_HI:SS_LINE_LO];
  wire [1:0] selGroup = secondary_select_word[SS_GRP_HI:SS_GRP_LO];
  wire [1:0] wrSel    = ctlWrData[CW_SEL_HI:CW_SEL_LO];
  wire [3:0] wrNibble = ctlWrData[CW_DATA_HI:CW_DATA_LO];
  wire [4:0] wrGroup  = {ctlWrData[14], ctlWrData[12:9]};
  wire       selAsync = lineAsync[selLine];

  // Popping a head into the word only when the word is empty keeps order
  wire headTake = headOk && !evtValid_q;
  wire evtRead  = evtRdEn && evtValid_q;

  // Control word readback: strobe and write-only fields read zero
  wire [15:0] ctlRead = {5'h00, regSel_q, 3'h0, extAddrHi, 4'h0};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regSel_q <= RST_SEL;
    end else if (busInit) begin
      regSel_q <= RST_SEL;
    end else if (ctlWrEn) begin
      regSel_q <= wrSel;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      line_control_word_q <= RST_WORD;
    end else begin
      line_control_word_q <= ctlRead;
    end
  end

  // Per-line settings and derived line controls
  for (genvar ln = 0; ln < NUM_LINES; ln++) begin : g_line
    wire hitLine = strobe && (selLine == 4'(ln));
    wire hitAsync = hitLine && selAsync;
    wire hitSync  = hitLine && !selAsync;
    lcev_async_set_t cur;
    assign cur = asyncSet_q[ln];
    wire halfDup = cur.primary[PR_HALFDUP];
    wire rxEn    = lineAsync[ln] ? cur.primary[PR_RXEN] : syncRxEn_q[ln];
    wire looped  = cur.maint[MT_LOOP];

    // Same-edge update so the next write can retarget another line
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        asyncSet_q[ln] <= '0;
      end else if (busInit) begin
        asyncSet_q[ln] <= '0;
      end else if (hitAsync) begin
        case (wrSel)
          SEL_PRIMARY: asyncSet_q[ln].primary <= wrNibble;
          SEL_FORMAT:  asyncSet_q[ln].format  <= wrNibble;
          SEL_BAUD:    asyncSet_q[ln].baud    <= wrNibble;
          default:     asyncSet_q[ln].maint   <= wrNibble;
        endcase
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        syncRxEn_q[ln] <= 1'b0;
      end else if (busInit) begin
        syncRxEn_q[ln] <= 1'b0;
      end else if (hitSync) begin
        syncRxEn_q[ln] <= ctlWrData[CW_SYNC_RXEN];
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        rxGate_q[ln]     <= 1'b0;
        rxActive_q[ln]   <= 1'b0;
        rxSerial_q[ln]   <= 1'b1;
        lineTxd_q[ln]    <= 1'b1;
        remoteBusy_q[ln] <= 1'b0;
        charBits_q[ln]   <= CHAR_LEN_MIN;
        stopBits2_q[ln]  <= 1'b0;
        parityOn_q[ln]   <= 1'b0;
        parityEven_q[ln] <= 1'b0;
        speedCode_q[ln]  <= RST_NIBBLE;
      end else begin
        // Half duplex blinds the receiver only while this line is sending
        rxGate_q[ln]     <= rxEn && !(halfDup && txBusy[ln]);
        rxActive_q[ln]   <= rxEn && !rxResync[ln] && !busInit
                            && (rxActive_q[ln] || rxEn);
        rxSerial_q[ln]   <= looped ? txSerial[ln] : rxLineIn[ln];
        // Break holds space; characters still shift but never leave
        lineTxd_q[ln]    <= !looped && !cur.primary[PR_BREAK] && txSerial[ln];
        remoteBusy_q[ln] <= !looped && remoteBusyIn[ln];
        charBits_q[ln]   <= CHAR_LEN_MIN + {2'h0, cur.format[FM_LEN_HI:FM_LEN_LO]};
        stopBits2_q[ln]  <= cur.format[FM_TWOSTOP];
        parityOn_q[ln]   <= cur.format[FM_PAREN];
        // Sense only matters when parity is on; host sets it first
        parityEven_q[ln] <= cur.format[FM_PAREN] && cur.primary[PR_EVENPAR];
        speedCode_q[ln]  <= cur.baud;
      end
    end
  end

  // Four-line group storage for sync cards
  for (genvar gr = 0; gr < NUM_GROUPS; gr++) begin : g_group
    wire hitGroup = strobe && !selAsync && (selGroup == 2'(gr));
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        syncGroupCtl_q[gr] <= RST_GROUP;
      end else if (busInit) begin
        syncGroupCtl_q[gr] <= RST_GROUP;
      end else if (hitGroup) begin
        syncGroupCtl_q[gr] <= wrGroup;
      end
    end
  end

  // Receive interrupt word; the character byte arrives already packed with
  // any short-character parity bit just above its top data bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      receive_interrupt_word_q <= '0;
    end else if (busInit) begin
      receive_interrupt_word_q <= '0;
    end else if (rxWordLoad) begin
      receive_interrupt_word_q <= rxWordIn;
    end
  end

  lcev_event_fifo u_fifo (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .push       (txEvtPush),
    .pushData   (txEvtIn),
    .pop        (headTake),
    .full       (fifoFull),
    .headOk_q   (headOk),
    .headData_q (headData)
  );

  // Only the valid flag is cleared by initialize; data bits hold
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evtValid_q <= 1'b0;
      evtData_q  <= '0;
    end else begin
      if (busInit) begin
        evtValid_q <= 1'b0;
      end else if (headTake) begin
        evtValid_q <= 1'b1;
      end else if (evtRead) begin
        evtValid_q <= 1'b0;
      end
      if (headTake && !busInit) begin
        evtData_q <= headData;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      transmit_event_word_q <= RST_WORD;
      txEvtFull_q           <= 1'b0;
    end else begin
      transmit_event_word_q <= {evtValid_q, evtData_q};
      txEvtFull_q           <= fifoFull;
    end
  end

endmodule : lcev_regs

// ===== test/lcev_host_model.sv
// Host program model: control word writes, resync and event word reads
`timescale 1ns/1ps
module lcev_host_model (
  input  wire logic  clk_sys,
  output logic       ctlWrEn,
  output logic [15:0] ctlWrData,
  output logic [15:0] secondary_select_word,
  output logic       evtRdEn,
  output logic [15:0] rxResync
);
  localparam int CharCycles = 16;
  initial begin
    ctlWrEn = 1'b0;
    ctlWrData = 16'h0000;
    secondary_select_word = 16'h0000;
    evtRdEn = 1'b0;
    rxResync = 16'h0000;
  end
  // Entered after a falling edge; strobe stays up so writes can follow back to back
  task automatic wr(input logic [3:0] ln, input logic [15:0] d);
    secondary_select_word = {12'h000, ln};
    ctlWrData = d;
    ctlWrEn = 1'b1;
    @(negedge clk_sys);
  endtask : wr
  task automatic idle();
    ctlWrEn = 1'b0;
    @(negedge clk_sys);
  endtask : idle
  task automatic setup(input logic [3:0] ln, input logic [3:0] pri, input logic [3:0] fmt);
    wr(ln, {1'b1, pri, 2'h0, 9'h000});
    wr(ln, {1'b1, fmt, 2'h1, 9'h000});
    idle();
  endtask : setup
  task automatic stop_rx(input logic [3:0] ln);
    wr(ln, 16'h8000);
    idle();
    rxResync[ln] = 1'b1;
    @(negedge clk_sys);
    rxResync[ln] = 1'b0;
    repeat (CharCycles) @(negedge clk_sys);
  endtask : stop_rx
  task automatic rd_evt();
    evtRdEn = 1'b1;
    @(negedge clk_sys);
    evtRdEn = 1'b0;
  endtask : rd_evt
endmodule : lcev_host_model

// ===== test/lcev_regs_sva.sv
// Assertion checker for the line configuration and event registers
`timescale 1ns/1ps
module lcev_regs_sva
  import lcev_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire logic                        busInit,
  input wire logic                        ctlWrEn,
  input wire logic [15:0]                 ctlWrData,
  input wire logic [15:0]                 secondary_select_word,
  input wire logic [1:0]                  extAddrHi,
  input wire logic [NUM_LINES-1:0]        lineAsync,
  input wire logic                        rxWordLoad,
  input wire lcev_rx_word_t               rxWordIn,
  input wire logic                        evtRdEn,
  input wire logic [15:0]                 line_control_word_q,
  input wire lcev_rx_word_t               receive_interrupt_word_q,
  input wire logic [15:0]                 transmit_event_word_q,
  input wire lcev_async_set_t [NUM_LINES-1:0] asyncSet_q,
  input wire logic [NUM_LINES-1:0]        syncRxEn_q,
  input wire logic [NUM_GROUPS-1:0][4:0]  syncGroupCtl_q,
  input wire logic [NUM_LINES-1:0][3:0]   charBits_q,
  input wire logic [NUM_LINES-1:0][3:0]   speedCode_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire [3:0] selLine = secondary_select_word[3:0];
  wire [1:0] selCode = ctlWrData[10:9];
  wire       strb    = ctlWrEn && ctlWrData[CW_STROBE] && !busInit;
  a_async_load: assert property (strb && lineAsync[selLine] |=>
    asyncSet_q[$past(selLine)][$past(selCode)*4 +: 4] == $past(ctlWrData[14:11]))
    else $error("async settings nibble not loaded");
  a_sync_rxen: assert property (strb && !lineAsync[selLine] |=>
    syncRxEn_q[$past(selLine)] == $past(ctlWrData[13])) else $error("sync enable not loaded");
  a_sync_group: assert property (strb && !lineAsync[selLine] |=>
    syncGroupCtl_q[$past(selLine[3:2])] == {$past(ctlWrData[14]), $past(ctlWrData[12:9])})
    else $error("group storage not loaded");
  a_strobe_reads: assert property (line_control_word_q[CW_STROBE] == 1'b0)
    else $error("strobe bit reads back set");
  a_init_clear: assert property (busInit && !ctlWrEn && !rxWordLoad |=>
    asyncSet_q == '0 && syncRxEn_q == '0 && receive_interrupt_word_q == '0)
    else $error("initialize left state behind");
  a_rx_load: assert property (rxWordLoad && !busInit |=>
    receive_interrupt_word_q == $past(rxWordIn)) else $error("receive word not loaded");
  a_ext_addr: assert property ($past(rst_n) |->
    line_control_word_q[5:4] == $past(extAddrHi)) else $error("extended address readback");
  a_valid_drop: assert property (evtRdEn && transmit_event_word_q[EV_VALID] |->
    ##[1:4] !transmit_event_word_q[EV_VALID]) else $error("event valid not cleared");
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
    a_char_len: assert property (!$past(busInit) |->
      charBits_q[i] == 4'h5 + $past(asyncSet_q[i].format[1:0])) else $error("length");
    a_speed_code: assert property (!$past(busInit) |->
      speedCode_q[i] == $past(asyncSet_q[i].baud)) else $error("speed code");
  end
  c_async_write: cover property (strb && lineAsync[selLine]);
  c_sync_write: cover property (strb && !lineAsync[selLine]);
  c_event_read: cover property (evtRdEn && transmit_event_word_q[EV_VALID]);
endmodule : lcev_regs_sva
bind lcev_regs lcev_regs_sva chk_u (.clk_sys, .rst_n, .busInit, .ctlWrEn, .ctlWrData,
  .secondary_select_word, .extAddrHi, .lineAsync, .rxWordLoad, .rxWordIn, .evtRdEn,
  .line_control_word_q, .receive_interrupt_word_q, .transmit_event_word_q, .asyncSet_q,
  .syncRxEn_q, .syncGroupCtl_q, .charBits_q, .speedCode_q);

// ===== test/testbench.sv
// Self-checking testbench for the line configuration and event registers
`timescale 1ns/1ps
module testbench import lcev_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic busInit = 1'b0;
  logic [1:0] extAddrHi = 2'h2;
  logic [15:0] lineAsync = 16'hfff0;
  logic rxWordLoad = 1'b0;
  lcev_rx_word_t rxWordIn = '0;
  logic txEvtPush = 1'b0;
  lcev_tx_event_t txEvtIn = '0;
  logic [15:0] txSerial = 16'hffff;
  logic [15:0] txBusy = 16'h0000, rxLineIn = 16'h0000, remoteBusyIn = 16'h0000;
  logic [15:0] rxGate_q, rxSerial_q, remoteBusy_q;
  logic txEvtFull_q;
  wire ctlWrEn, evtRdEn;
  wire [15:0] ctlWrData, secondary_select_word, rxResync;
  logic [15:0] line_control_word_q, transmit_event_word_q;
  lcev_rx_word_t receive_interrupt_word_q;
  lcev_async_set_t [15:0] asyncSet_q;
  logic [15:0] syncRxEn_q, rxActive_q, lineTxd_q, stopBits2_q, parityOn_q, parityEven_q;
  logic [3:0][4:0] syncGroupCtl_q;
  logic [15:0][3:0] charBits_q, speedCode_q;
  wire [3:0] line7Ctl = {rxGate_q[7], rxSerial_q[7], remoteBusy_q[7], lineTxd_q[7]};
  int failures = 0;
  int checks_done = 0;
  always #12.5 clk_sys = ~clk_sys;
  lcev_host_model host_u (.clk_sys, .ctlWrEn, .ctlWrData, .secondary_select_word,
    .evtRdEn, .rxResync);
  lcev_regs dut_u (.clk_sys, .rst_n, .busInit, .ctlWrEn, .ctlWrData,
    .secondary_select_word, .extAddrHi, .lineAsync, .rxWordLoad, .rxWordIn, .evtRdEn,
    .txEvtPush, .txEvtIn, .txBusy, .txSerial, .rxLineIn,
    .remoteBusyIn, .rxResync, .line_control_word_q, .receive_interrupt_word_q,
    .transmit_event_word_q, .txEvtFull_q, .asyncSet_q, .syncRxEn_q, .syncGroupCtl_q,
    .rxGate_q, .rxActive_q, .rxSerial_q, .lineTxd_q, .remoteBusy_q, .charBits_q,
    .stopBits2_q, .parityOn_q, .parityEven_q, .speedCode_q);
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("Checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // Bounded wait for the event valid flag
  task automatic wait_ev(input logic v);
    int n;
    for (n = 0; n < 20 && transmit_event_word_q[EV_VALID] !== v; n++) @(negedge clk_sys);
    if (n == 20) begin
      chk("eventValid", {15'h0000, v}, {15'h0000, transmit_event_word_q[EV_VALID]});
      results();
    end
  endtask : wait_ev
  task automatic push(input logic [14:0] e);
    txEvtIn = e;
    txEvtPush = 1'b1;
    @(negedge clk_sys);
  endtask : push
  initial begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("resetSet", 16'h0000, asyncSet_q[5]);
    chk("resetLen", 16'h0005, {12'h000, charBits_q[5]});
    for (int s = 0; s < 4; s++) begin
      host_u.wr(4'h5, {1'b1, 4'(s + 9), 2'(s), 9'h000});
      host_u.idle();
      chk("nibble", {12'h000, 4'(s + 9)}, {12'h000, asyncSet_q[5][s*4 +: 4]});
      chk("ctlRead", {5'h00, 2'(s), 7'h08, 2'h0}, line_control_word_q);
    end
    chk("length", 16'h0007, {12'h000, charBits_q[5]});
    chk("parity", 16'h0002, {14'h0000, parityOn_q[5], parityEven_q[5]});
    chk("speed", 16'h000b, {12'h000, speedCode_q[5]});
    chk("break", 16'h0000, {15'h0000, lineTxd_q[5]});
    $display("test async registers done");
    host_u.setup(4'h6, 4'h6, 4'he);
    chk("line6", 16'h00e6, asyncSet_q[6]);
    chk("fmt6", 16'h0007, {13'h0, parityOn_q[6], parityEven_q[6], stopBits2_q[6]});
    chk("rxOn", 16'h0001, {15'h0000, rxActive_q[6]});
    host_u.stop_rx(4'h6);
    chk("rxOff", 16'h0000, {15'h0000, rxActive_q[6]});
    $display("test receiver enable done");
    host_u.wr(4'h7, 16'ha800);
    host_u.wr(4'h7, 16'h8e00);
    host_u.idle();
    txBusy[7] = 1'b1;
    remoteBusyIn[7] = 1'b1;
    @(negedge clk_sys);
    chk("looped", 16'h0004, {12'h000, line7Ctl});
    txBusy[7] = 1'b0;
    host_u.wr(4'h7, 16'h8600);
    host_u.idle();
    chk("unlooped", 16'h000b, {12'h000, line7Ctl});
    $display("test line controls done");
    host_u.wr(4'h2, 16'hf600);
    host_u.wr(4'h3, 16'h9200);
    host_u.wr(4'h2, 16'h0000);
    host_u.idle();
    chk("syncEn", 16'h0004, {12'h000, syncRxEn_q[3:0]});
    chk("group0", 16'h0009, {11'h000, syncGroupCtl_q[0]});
    $display("test sync storage done");
    rxWordIn = 16'h7a5c;
    rxWordLoad = 1'b1;
    @(negedge clk_sys);
    rxWordLoad = 1'b0;
    chk("rxWord", 16'h7a5c, receive_interrupt_word_q);
    host_u.wr(4'h5, 16'h0600);
    host_u.idle();
    chk("selSet", 16'h0600, line_control_word_q & 16'h0600);
    busInit = 1'b1;
    @(negedge clk_sys);
    busInit = 1'b0;
    @(negedge clk_sys);
    chk("initRx", 16'h0000, receive_interrupt_word_q);
    chk("initSet", 16'h0000, asyncSet_q[5]);
    chk("initSel", 16'h0000, line_control_word_q & 16'h0600);
    $display("test initialize done");
    push(15'h4123);
    push(15'h7fff);
    txEvtPush = 1'b0;
    wait_ev(1'b1);
    chk("event1", 16'hc123, transmit_event_word_q);
    host_u.rd_evt();
    wait_ev(1'b0);
    wait_ev(1'b1);
    chk("event2", 16'hffff, transmit_event_word_q);
    host_u.rd_evt();
    wait_ev(1'b0);
    repeat (8) @(negedge clk_sys);
    host_u.rd_evt();
    repeat (4) @(negedge clk_sys);
    chk("emptyRd", 16'h0000, {15'h0000, transmit_event_word_q[EV_VALID]});
    push(15'h0001);
    txEvtPush = 1'b0;
    wait_ev(1'b1);
    chk("event3", 16'h8001, transmit_event_word_q);
    for (int i = 0; i < 65; i++) push(15'(i));
    txEvtPush = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("full", 16'h0001, {15'h0000, txEvtFull_q});
    host_u.rd_evt();
    wait_ev(1'b0);
    wait_ev(1'b1);
    chk("oldest", 16'h8000, transmit_event_word_q);
    chk("notFull", 16'h0000, {15'h0000, txEvtFull_q});
    $display("test event word done");
    results();
  end
endmodule : testbench
